/* File: design/utf_pkg.sv */
// Package with constants and types for the ultrasonic ToF sequencer
package utf_pkg;
   // ************************************************************
   // Register map (word addresses on the plain register port)
   // ************************************************************
   localparam logic [3:0] ADDR_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_DELAYS = 4'h1;
   localparam logic [3:0] ADDR_MASK = 4'h2;
   localparam logic [3:0] ADDR_WAVE = 4'h3;
   localparam logic [3:0] ADDR_OFFSET = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h5;
   localparam logic [3:0] ADDR_RES0 = 4'h6;
   localparam logic [3:0] ADDR_RES1 = 4'h7;
   localparam logic [3:0] ADDR_RES2 = 4'h8;
   localparam logic [3:0] ADDR_RES4 = 4'h9;
   localparam logic [3:0] ADDR_RATIO = 4'hA;
   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTL_GO = 0;
   localparam int CTL_MODE2 = 1;
   localparam int CTL_ANALOG = 2;
   localparam int CTL_PW_OFF = 16;
   localparam int CTL_FW_EN = 30;
   localparam int CTL_STOPS_LSB = 4;
   localparam int TRIM_LSB = 25;
   localparam int TRIM_W = 4;
   localparam int FWOFS_LSB = 8;
   localparam int FWOFS_W = 5;
   localparam int RNG_NEG = 13;
   localparam int RNG_POS = 14;
   localparam int RNG_STEP = 20;
   localparam int WSEL_W = 6;
   localparam logic [5:0] WSEL_MIN = 6'h03;
   localparam logic [5:0] WSEL_MAX = 6'h3F;
   localparam int MAX_STOPS = 3;
   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [31:0] CONTROL_RST = 32'h0000_0006;
   localparam logic [31:0] DELAYS_RST = 32'h0010_0010;
   localparam logic [31:0] MASK_RST = 32'h0000_0040;
   localparam logic [31:0] WAVE_RST = 32'h0001_4103;
   localparam logic [31:0] OFFSET_RST = 32'h0000_0000;
   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_MHZ = 50;
   localparam int MAINS_50_MS = 20;
   localparam int TIMEOUT_US = 4096;
   localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
   localparam int MAINS_CYC = MAINS_50_MS * 1000 * CLK_MHZ;
   // ************************************************************
   // Sequencer states
   // ************************************************************
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_OSC = 4'b0001,
      ST_POWER = 4'b0010,
      ST_CHARGE = 4'b0011,
      ST_FIRE = 4'b0100,
      ST_MASK = 4'b0101,
      ST_FIRST = 4'b0110,
      ST_WIDTH = 4'b0111,
      ST_STOPS = 4'b1000,
      ST_CALC = 4'b1001,
      ST_DOWN = 4'b1010,
      ST_WAIT = 4'b1011
   } utf_state_type;
endpackage

/* File: design/utf_sequencer.sv */
// Two-direction ultrasonic ToF sequencer with first-wave mode
// Overview of operation
// - Restart command runs a sequence whose first pass is upstream.
// - Switch on fast oscillator, wait programmed settling delay.
// - Then power comparator, reference, switches; off outside measurement.
// - Ground transmit capacitor and downstream fire buffer before upstream fire.
// - Charge receive capacitor to reference, wait receive charge delay.
// - Route receive input to comparator; upstream fire starts timing.
// - Emit configured number of fire pulses on upstream buffer.
// - Comparator feeds stop; stops accepted after mask; at most three.
// - At direction end power everything down, then set interrupt flag.
// - After interrupt wait mains-period multiples; host reads results then.
// - Then repeat with roles swapped, measuring downstream.
// - Offset trim is four-bit two's complement at bits 25..28.
// - First-wave mode adds selectable offset from -36 to +35 mV.
// - Before first-wave detection apply first-wave offset; first mask applies.
// - Time first wave rising to falling edge, then offset back to zero.
// - Three stops chosen by relative wave counts after first wave.
// - Measure first timed half-wave, report first-wave ratio to it.
// - First-wave mode computes three results and average at result 4.
// - No signal above raised offset: keep offset, time out, flag empty.
// - First-wave mode works only in mode two with analog path.
// - Wave selects ascending, first at least three, none above 63.
// - Ratio is 8-bit fixed point, one integer bit; can be disabled.
// - Bit 30 enables first-wave mode, selecting stops by wave register fields.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module utf_sequencer #(
   parameter int TIMEOUT_CYCLES = utf_pkg::TIMEOUT_CYC,
   parameter int MAINS_CYCLES = utf_pkg::MAINS_CYC,
   parameter int CNT_W = 24
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic comparator_out,
   output logic osc_enable,
   output logic analog_power,
   output logic transmit_path_ground,
   output logic receive_path_charge,
   output logic receive_path_input_select,
   output logic fire_up,
   output logic fire_down,
   output logic fire_up_ground,
   output logic fire_down_ground,
   output logic tdc_start_select,
   output logic [6:0] comparator_offset,
   output logic irq_flag,
   output logic direction_down
);
   import utf_pkg::*;

   initial begin
      if (CNT_W < 16 || CNT_W > 31) $error("CNT_W out of range");
      if (TIMEOUT_CYCLES < 1 || MAINS_CYCLES < 1) $error("bad counts");
      if (64'(TIMEOUT_CYCLES) >= (64'h1 << CNT_W)
          || 64'(MAINS_CYCLES) >= (64'h1 << CNT_W)) $error("counts too wide");
   end

   // ************************************************************
   // Registers
   // ************************************************************
   logic [31:0] control;
   logic [31:0] delays;
   logic [31:0] mask;
   logic [31:0] wave;
   logic [31:0] offset_cfg;
   utf_state_type state;
   logic [CNT_W-1:0] cnt;
   logic [CNT_W-1:0] tof;
   logic [CNT_W-1:0] res [MAX_STOPS];
   logic [CNT_W-1:0] fw_width;
   logic [CNT_W-1:0] hwp_start;
   logic [CNT_W-1:0] hwp;
   logic [7:0] ratio;
   logic [5:0] wave_cnt;
   logic [1:0] stop_idx;
   logic [2:0] pulses;
   logic comp_q;
   logic empty_tube;
   logic timeout_flag;
   logic busy;
   logic [CNT_W+1:0] sum;

   wire fw_mode = control[CTL_FW_EN] & control[CTL_MODE2]
                  & control[CTL_ANALOG];
   wire rise = comparator_out & ~comp_q;
   wire fall = ~comparator_out & comp_q;
   wire [5:0] wsel [MAX_STOPS];
   assign wsel[0] = wave[5:0];
   assign wsel[1] = wave[13:8];
   assign wsel[2] = wave[21:16];
   // Bad wave programming is flagged in status, not clamped; stop count 0 becomes 1
   wire wsel_ok = (wsel[0] >= WSEL_MIN) && (wsel[1] > wsel[0])
                  && (wsel[2] > wsel[1]);
   wire [1:0] stops_req = control[CTL_STOPS_LSB +: 2];
   wire [1:0] stops_n = (stops_req == 2'd0) ? 2'd1
                        : (stops_req > 2'd3 ? 2'd3 : stops_req);

   // Software writes to configuration; go bit is self clearing
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         control <= CONTROL_RST;
         delays <= DELAYS_RST;
         mask <= MASK_RST;
         wave <= WAVE_RST;
         offset_cfg <= OFFSET_RST;
      end else begin
         if (reg_wr) begin
            unique case (reg_addr)
               ADDR_CONTROL: control <= reg_wdata;
               ADDR_DELAYS: delays <= reg_wdata;
               ADDR_MASK: mask <= reg_wdata;
               ADDR_WAVE: wave <= reg_wdata;
               ADDR_OFFSET: offset_cfg <= reg_wdata;
               default: ;
            endcase
         end else if (state != ST_IDLE) begin
            control[CTL_GO] <= 1'b0;
         end
      end
   end

   // Read data one cycle after strobe; unmapped reads zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CONTROL: reg_rdata <= control;
            ADDR_DELAYS: reg_rdata <= delays;
            ADDR_MASK: reg_rdata <= mask;
            ADDR_WAVE: reg_rdata <= wave;
            ADDR_OFFSET: reg_rdata <= offset_cfg;
            ADDR_STATUS: reg_rdata <= {26'h0, wsel_ok, timeout_flag,
                                       empty_tube, direction_down,
                                       busy, irq_flag};
            ADDR_RES0: reg_rdata <= 32'(res[0]);
            ADDR_RES1: reg_rdata <= 32'(res[1]);
            ADDR_RES2: reg_rdata <= 32'(res[2]);
            ADDR_RES4: reg_rdata <=
               32'(sum / (CNT_W+2)'(MAX_STOPS));
            ADDR_RATIO: reg_rdata <= {24'h0, ratio};
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end

   // Comparator history for edge detection
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         comp_q <= 1'b0;
      end else begin
         comp_q <= comparator_out;
      end
   end

   // Main sequencer
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state <= ST_IDLE;
         cnt <= '0;
         tof <= '0;
         wave_cnt <= 6'h00;
         stop_idx <= 2'd0;
         pulses <= 3'd0;
         busy <= 1'b0;
         direction_down <= 1'b0;
         irq_flag <= 1'b0;
         empty_tube <= 1'b0;
         timeout_flag <= 1'b0;
         fw_width <= '0;
         hwp_start <= '0;
         hwp <= '0;
         for (int i = 0; i < MAX_STOPS; i++) begin
            res[i] <= '0;
         end
      end else begin
         if (reg_rd && reg_addr == ADDR_STATUS) begin
            irq_flag <= 1'b0;
         end
         if (state inside {ST_FIRE, ST_MASK, ST_FIRST, ST_WIDTH, ST_STOPS}) begin
            tof <= tof + 1'b1;
         end
         unique case (state)
            ST_IDLE: begin
               if (control[CTL_GO]) begin
                  direction_down <= 1'b0;
                  busy <= 1'b1;
                  empty_tube <= 1'b0;
                  timeout_flag <= 1'b0;
                  cnt <= '0;
                  state <= ST_OSC;
               end
            end
            ST_OSC: begin
               cnt <= cnt + 1'b1;
               if (cnt >= CNT_W'(delays[15:0])) begin
                  cnt <= '0;
                  state <= ST_POWER;
               end
            end
            ST_POWER: begin
               state <= ST_CHARGE;
            end
            ST_CHARGE: begin
               cnt <= cnt + 1'b1;
               if (cnt >= CNT_W'(delays[31:16])) begin
                  cnt <= '0;
                  pulses <= 3'd0;
                  tof <= '0;
                  state <= ST_FIRE;
               end
            end
            ST_FIRE: begin
               cnt <= cnt + 1'b1;
               if (cnt[0]) begin
                  pulses <= pulses + 1'b1;
                  if (pulses + 1'b1 >= 3'(mask[31:29] == 3'd0 ? 3'd1
                                            : mask[31:29])) begin
                     cnt <= '0;
                     state <= ST_MASK;
                  end
               end
            end
            ST_MASK: begin
               stop_idx <= 2'd0;
               wave_cnt <= 6'h00;
               // First mask blocks early noise in both modes
               if (tof >= CNT_W'(mask[15:0])) begin
                  state <= fw_mode ? ST_FIRST : ST_STOPS;
               end
            end
            ST_FIRST: begin
               if (rise) begin
                  hwp_start <= tof;
                  state <= ST_WIDTH;
               end
            end
            ST_WIDTH: begin
               if (fall) begin
                  fw_width <= tof - hwp_start;
                  state <= ST_STOPS;
               end
            end
            ST_STOPS: begin
               if (rise) begin
                  wave_cnt <= wave_cnt + 1'b1;
                  // Non-first-wave mode takes consecutive rises
                  if (!fw_mode || (wave_cnt + 1'b1 == wsel[stop_idx]
                      && wave_cnt != WSEL_MAX)) begin
                     res[stop_idx] <= tof;
                     if (stop_idx == 2'd0) hwp_start <= tof;
                     if (stop_idx + 1'b1 >= (fw_mode ? 2'd3 : stops_n)) begin
                        state <= ST_CALC;
                     end
                     stop_idx <= stop_idx + 1'b1;
                  end
               end
               if (fall && stop_idx == 2'd1 && hwp == '0) begin
                  hwp <= tof - hwp_start;
               end
            end
            ST_CALC: begin
               cnt <= '0;
               state <= ST_DOWN;
            end
            ST_DOWN: begin
               irq_flag <= 1'b1;
               state <= ST_WAIT;
            end
            ST_WAIT: begin
               cnt <= cnt + 1'b1;
               if (cnt >= CNT_W'(MAINS_CYCLES)) begin
                  cnt <= '0;
                  hwp <= '0;
                  if (direction_down) begin
                     busy <= 1'b0;
                     state <= ST_IDLE;
                  end else begin
                     direction_down <= 1'b1;
                     state <= ST_OSC;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
         // Timeout ends measurement; first-wave offset is kept only if no first wave came
         if (state inside {ST_MASK, ST_FIRST, ST_WIDTH, ST_STOPS}
             && tof >= CNT_W'(TIMEOUT_CYCLES)) begin
            timeout_flag <= 1'b1;
            empty_tube <= fw_mode && state == ST_FIRST;
            state <= ST_DOWN;
         end
      end
   end

   // Sum of three results for averaging
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sum <= '0;
      end else if (state == ST_CALC) begin
         sum <= (CNT_W+2)'(res[0]) + (CNT_W+2)'(res[1])
                + (CNT_W+2)'(res[2]);
      end
   end

   // Width ratio, Q1.7; cleared when disabled
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ratio <= 8'h00;
      end else if (state == ST_CALC) begin
         if (control[CTL_PW_OFF] || !fw_mode || hwp == '0) begin
            ratio <= 8'h00;
         end else if (fw_width >= (hwp << 1)) begin
            ratio <= 8'hFF;
         end else begin
            ratio <= 8'((fw_width << 7) / hwp);
         end
      end
   end

   // Analog path control outputs
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         osc_enable <= 1'b0;
         analog_power <= 1'b0;
         transmit_path_ground <= 1'b0;
         receive_path_charge <= 1'b0;
         receive_path_input_select <= 1'b0;
         fire_up <= 1'b0;
         fire_down <= 1'b0;
         fire_up_ground <= 1'b0;
         fire_down_ground <= 1'b0;
         tdc_start_select <= 1'b0;
      end else begin
         osc_enable <= !(state inside {ST_IDLE, ST_DOWN, ST_WAIT});
         analog_power <= !(state inside {ST_IDLE, ST_OSC, ST_DOWN,
                                         ST_WAIT});
         transmit_path_ground <= !(state inside {ST_IDLE, ST_OSC,
                                   ST_DOWN, ST_WAIT});
         fire_down_ground <= !direction_down && !(state inside {ST_IDLE,
                             ST_OSC, ST_DOWN, ST_WAIT});
         fire_up_ground <= direction_down && !(state inside {ST_IDLE,
                           ST_OSC, ST_DOWN, ST_WAIT});
         receive_path_charge <= (state == ST_CHARGE);
         receive_path_input_select <= direction_down;
         tdc_start_select <= direction_down;
         fire_up <= !direction_down && state == ST_FIRE && !cnt[0];
         fire_down <= direction_down && state == ST_FIRE && !cnt[0];
      end
   end

   // Comparator offset: trim, plus first-wave offset until width done
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         comparator_offset <= 7'h00;
      end else if (fw_mode && (state inside {ST_FIRE, ST_MASK, ST_FIRST,
                   ST_WIDTH} || (state == ST_DOWN && empty_tube))) begin
         // Raised with the fire burst; seven bits hold the full swing
         comparator_offset <= 7'(signed'(offset_cfg[FWOFS_LSB +: FWOFS_W]))
            + 7'(signed'(control[TRIM_LSB +: TRIM_W]))
            + (offset_cfg[RNG_POS] ? 7'(RNG_STEP) : 7'h00)
            - (offset_cfg[RNG_NEG] ? 7'(RNG_STEP) : 7'h00);
      end else begin
         comparator_offset <=
            7'(signed'(control[TRIM_LSB +: TRIM_W]));
      end
   end
endmodule

/* File: dv/utf_seq_props.sv */
// Concurrent checks on the ToF sequencer's analog control outputs
`timescale 1ns/1ns
module utf_seq_props (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic osc_enable,
   input wire logic analog_power,
   input wire logic transmit_path_ground,
   input wire logic receive_path_charge,
   input wire logic receive_path_input_select,
   input wire logic fire_up,
   input wire logic fire_down,
   input wire logic fire_up_ground,
   input wire logic fire_down_ground,
   input wire logic tdc_start_select,
   input wire logic irq_flag,
   input wire logic direction_down
);
   // ************************************************************
   // Sequencing properties
   // ************************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);
   // Analog parts only ever run on a live oscillator
   power_needs_osc_a: assert property (analog_power |-> osc_enable)
      else $error("analog power without oscillator");
   // Settling delay in the bench is never below eight cycles
   osc_settle_a: assert property ($rose(osc_enable) |-> !analog_power [*8])
      else $error("analog power before oscillator settled");
   up_ground_a: assert property (fire_up |-> transmit_path_ground && fire_down_ground && !fire_up_ground)
      else $error("upstream fire without grounded idle path");
   up_route_a: assert property (fire_up |-> !direction_down && !receive_path_input_select && !tdc_start_select)
      else $error("upstream fire with wrong routing");
   down_route_a: assert property (fire_down |-> direction_down && receive_path_input_select && tdc_start_select && fire_up_ground)
      else $error("downstream fire with roles not swapped");
   single_fire_a: assert property (!(fire_up && fire_down))
      else $error("both fire buffers active");
   charge_quiet_a: assert property (receive_path_charge |-> analog_power && !fire_up && !fire_down)
      else $error("charging while unpowered or firing");
   irq_after_down_a: assert property ($rose(irq_flag) |-> !analog_power && !osc_enable)
      else $error("interrupt before power down");
   mains_wait_a: assert property ($rose(irq_flag) |-> !osc_enable [*8])
      else $error("oscillator back right after interrupt");
   // Main scenarios
   up_fire_c: cover property ($rose(fire_up));
   down_fire_c: cover property ($rose(fire_down));
   down_irq_c: cover property ($rose(irq_flag) && direction_down);
endmodule

/* File: dv/utf_echo_model.sv */
// Receive path model: a burst of square waves after each fire burst
`timescale 1ns/1ns
module utf_echo_model #(
   parameter int ECHO_DLY = 24,
   parameter int HALF = 4,
   parameter int N_HALF = 30
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic fire_up,
   input wire logic fire_down,
   input wire logic echo_on,
   output logic comparator_out
);
   logic fire_q;
   int cnt;
   // Equal half waves, so the width ratio is exactly one; no echo when off
   always_ff @(posedge sys_clk) begin
      fire_q <= fire_up | fire_down;
      if (reset) begin
         cnt <= 0;
         comparator_out <= 1'b0;
      end else if (cnt == 0) begin
         comparator_out <= 1'b0;
         if ((fire_up | fire_down) && !fire_q && echo_on) begin
            cnt <= 1;
         end
      end else begin
         cnt <= (cnt >= ECHO_DLY + HALF * N_HALF) ? 0 : cnt + 1;
         comparator_out <= (cnt >= ECHO_DLY) &&
            (((cnt - ECHO_DLY) / HALF) % 2 == 0);
      end
   end
endmodule

/* File: dv/test_ultrasonic_tof_first_wave_sequencer.sv */
// Self-checking bench for the two-direction ToF sequencer
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module test_ultrasonic_tof_first_wave_sequencer;
   import utf_pkg::*;
   logic sys_clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, echo_on = 1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, d, r0, r1, r2;
   logic comparator_out, osc_enable, analog_power, transmit_path_ground;
   logic receive_path_charge, receive_path_input_select, fire_up;
   logic fire_down, fire_up_ground, fire_down_ground, tdc_start_select;
   logic irq_flag, direction_down, fu_q = 0, fd_q = 0, irq_q = 0, osc_q = 0;
   logic [6:0] comparator_offset, fw_ofs;
   int n_errors = 0, total_checks = 0, cyc = 0, n_up = 0, n_down = 0;
   int gap = 0, last_gap = 0;
   utf_sequencer #(.TIMEOUT_CYCLES(500), .MAINS_CYCLES(200)) dut (
      .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .comparator_out(comparator_out),
      .osc_enable(osc_enable), .analog_power(analog_power),
      .transmit_path_ground(transmit_path_ground),
      .receive_path_charge(receive_path_charge),
      .receive_path_input_select(receive_path_input_select),
      .fire_up(fire_up), .fire_down(fire_down),
      .fire_up_ground(fire_up_ground), .fire_down_ground(fire_down_ground),
      .tdc_start_select(tdc_start_select),
      .comparator_offset(comparator_offset), .irq_flag(irq_flag),
      .direction_down(direction_down));
   utf_echo_model echo (.sys_clk(sys_clk), .reset(reset), .fire_up(fire_up),
      .fire_down(fire_down), .echo_on(echo_on),
      .comparator_out(comparator_out));
   // ************************************************************
   // Clock, pulse counters and hang guard
   // ************************************************************
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   // Gap counts cycles from interrupt to the next oscillator start
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      fu_q <= fire_up;
      fd_q <= fire_down;
      irq_q <= irq_flag;
      osc_q <= osc_enable;
      if (fire_up && !fu_q) n_up <= n_up + 1;
      if (fire_up && !fu_q && n_up == 0) fw_ofs <= comparator_offset;
      if (fire_down && !fd_q) n_down <= n_down + 1;
      gap <= (irq_flag && !irq_q) ? 0 : gap + 1;
      if (osc_enable && !osc_q) last_gap <= gap;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   // ************************************************************
   // Register port tasks and scenarios
   // ************************************************************
   task automatic wr(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Data stand from the cycle after the strobe until the next read
   task automatic rd(input logic [3:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_irq;
      int w;
      w = 0;
      while (irq_flag !== 1'b1 && w < 3000) begin
         @(posedge sys_clk);
         #1 w++;
      end
   endtask
   // A go written while busy is dropped, so wait for the sequence end
   task automatic wait_idle;
      logic [31:0] s;
      s = 32'h0000_0002;
      for (int k = 0; k < 300 && s[1]; k++) begin
         rd(ADDR_STATUS, s);
      end
      `CHK(s[1], 1'b0)
   endtask
   // Both passes; results read during the mains wait
   task automatic run(input logic [31:0] ctl, input logic [31:0] step,
         input logic fw);
      n_up = 0;
      n_down = 0;
      wait_idle();
      wr(ADDR_CONTROL, ctl);
      wait_irq();
      `CHK(irq_flag, 1'b1)
      `CHK(n_up, 3)
      `CHK(n_down, 0)
      `CHK(comparator_offset, 6'h00)
      rd(ADDR_STATUS, d);
      `CHK({d[2], d[0]}, 2'b01)
      `CHK(irq_flag, 1'b0)
      rd(ADDR_RES0, r0);
      rd(ADDR_RES1, r1);
      rd(ADDR_RES2, r2);
      `CHK(r1 - r0, step)
      `CHK(r2 - r1, step)
      if (fw) begin
         `CHK(fw_ofs, 6'd25)
         rd(ADDR_RES4, d);
         `CHK(d, (r0 + r1 + r2) / MAX_STOPS)
         rd(ADDR_RATIO, d);
         `CHK(d[7:0], 8'h80)
      end
      wait_irq();
      `CHK(n_down, 3)
      `CHK(last_gap >= 200, 1'b1)
      rd(ADDR_STATUS, d);
      `CHK({d[2], d[0]}, 2'b11)
   endtask
   task automatic summarize;
      $display("checks=%0d errors=%0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Reset values, configuration, plain, first-wave and empty-tube runs
   initial begin
      logic [3:0] ra[5];
      logic [31:0] rv[5];
      ra = '{ADDR_CONTROL, ADDR_DELAYS, ADDR_MASK, ADDR_WAVE, ADDR_OFFSET};
      rv = '{CONTROL_RST, DELAYS_RST, MASK_RST, WAVE_RST, OFFSET_RST};
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         rd(ra[i], d);
         `CHK(d, rv[i])
      end
      rd(4'hF, d);
      `CHK(d, 32'h0000_0000)
      wr(ADDR_CONTROL, 32'h1A00_0006);
      rd(ADDR_CONTROL, d);
      `CHK(d[28:25], 4'hD)
      wr(ADDR_DELAYS, 32'h000A_000A);
      wr(ADDR_MASK, 32'h6000_0008);
      wr(ADDR_WAVE, 32'h0007_0503);
      wr(ADDR_OFFSET, 32'h0000_4500);
      run(32'h0000_0037, 32'h0000_0008, 1'b0);
      run(32'h4000_0037, 32'h0000_0010, 1'b1);
      wait_idle();
      echo_on <= 1'b0;
      wr(ADDR_CONTROL, 32'h4000_0037);
      repeat (300) @(posedge sys_clk);
      #1 `CHK(comparator_offset, 6'd25)
      wait_irq();
      rd(ADDR_STATUS, d);
      `CHK(d[4:3], 2'b11)
      wait_irq();
      rd(ADDR_STATUS, d);
      `CHK(d[4:2], 3'b111)
      summarize();
   end
endmodule
bind utf_sequencer utf_seq_props chk (.sys_clk(sys_clk), .reset(reset),
   .osc_enable(osc_enable), .analog_power(analog_power),
   .transmit_path_ground(transmit_path_ground),
   .receive_path_charge(receive_path_charge),
   .receive_path_input_select(receive_path_input_select),
   .fire_up(fire_up), .fire_down(fire_down),
   .fire_up_ground(fire_up_ground), .fire_down_ground(fire_down_ground),
   .tdc_start_select(tdc_start_select), .irq_flag(irq_flag),
   .direction_down(direction_down));
